// >>> design/emr_pkg.sv
// Constants, field layouts and carrier types for the extended mode register block
package emr_pkg;
  // ----------------------------------------------------------------
  // Command decode and register selection
  // ----------------------------------------------------------------
  localparam int EMR_ADDR_W = 16;
  localparam int EMR_REG_W = 13;
  localparam logic [2:0] EMR_BA_EXT1 = 3'h1;
  localparam logic [2:0] EMR_BA_EXT2 = 3'h2;
  localparam logic [1:0] EMR_BA_SEL_MASK = 2'h3;
  // ----------------------------------------------------------------
  // Field positions of the first and second extended registers
  // ----------------------------------------------------------------
  localparam int EMR_DLL_DIS_POS = 0;
  localparam int EMR_DRIVE_POS = 1;
  localparam int EMR_TERM_LO_POS = 2;
  localparam int EMR_AL_LSB = 3;
  localparam int EMR_AL_W = 3;
  localparam int EMR_TERM_HI_POS = 6;
  localparam int EMR_OCD_LSB = 7;
  localparam int EMR_OCD_W = 3;
  localparam int EMR_COMP_DIS_POS = 10;
  localparam int EMR_RDQS_EN_POS = 11;
  localparam int EMR_OUT_DIS_POS = 12;
  localparam int EMR_REFRESH_POS = 7;
  localparam logic [EMR_REG_W-1:0] EMR_EXT1_RESET = 13'h0000;
  localparam logic [EMR_REG_W-1:0] EMR_EXT2_RESET = 13'h0000;
  // ----------------------------------------------------------------
  // Latency and timing
  // ----------------------------------------------------------------
  localparam logic [2:0] EMR_AL_MAX = 3'h6;
  localparam int EMR_AL_DEPTH = 6;
  localparam logic [2:0] EMR_CL_RESET = 3'h3;
  localparam int EMR_LAT_W = 4;
  localparam int EMR_DLL_LOCK_CLOCKS = 200;
  localparam int EMR_LOCK_CNT_W = 8;
  // ----------------------------------------------------------------
  // Register map on the software bus
  // ----------------------------------------------------------------
  localparam logic [3:0] EMR_OFF_EXT1 = 4'h0;
  localparam logic [3:0] EMR_OFF_EXT2 = 4'h4;
  localparam logic [3:0] EMR_OFF_CTRL = 4'h8;
  localparam logic [3:0] EMR_OFF_STAT = 4'hc;
  localparam logic [1:0] EMR_RESP_OKAY = 2'h0;
  localparam logic [1:0] EMR_RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {EMR_RTT_OFF, EMR_RTT_75, EMR_RTT_150, EMR_RTT_50} emr_rtt_e;
  typedef struct packed {
    logic dll_enable;
    logic drive_reduced;
    emr_rtt_e rtt;
    logic [EMR_AL_W-1:0] additive_latency;
    logic [EMR_OCD_W-1:0] ocd;
    logic comp_strobe_en;
    logic redundant_strobe_en;
    logic output_en;
    logic refresh_fast;
  } emr_fields_s;
  typedef struct packed {
    logic dq_oe;
    logic dqs_oe;
    logic dqs_comp_oe;
    logic rdqs_oe;
    logic rdqs_comp_oe;
  } emr_strobe_oe_s;
endpackage : emr_pkg

// >>> design/emr_top.sv
// Extended mode registers of the memory device with software readback
//
// How it works
// - Registers load only on load-mode command and hold otherwise.
// - DLL follows disable bit; controller keeps DLL on at init.
// - DLL turns off in self refresh, re-enables and resets on exit.
// - Drive bit zero gives full strength, one gives reduced strength.
// - Complementary strobe disable bit one makes the strobe single-ended.
// - Redundant complementary strobe needs redundant enable and complement enabled.
// - On x8, redundant strobe copies data strobe on reads, ignored on writes.
// - Output disable bit one clears all data and strobe output enables; rdqs_o is not gated by it.
// - Termination chosen from two select bits; all four combinations decoded, 11 as 50.
// - Termination follows ODT input only in active or power-down states.
// - Additive latency from three-bit field, zero to six clocks.
// - Read or write accepted early and delayed by additive latency.
// - Read latency is additive plus CAS; write latency one less.
// - Second register refresh-rate bit selects faster refresh.
// - Bank address one-zero pattern 01 selects the first register.
// - Bank address pattern 10 selects the second register.
`timescale 1ns/10ps
`default_nettype none
module emr_top
  import emr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Command and address bus, sampled on the device clock
  input wire logic cmd_cs_n_i,
  input wire logic cmd_ras_n_i,
  input wire logic cmd_cas_n_i,
  input wire logic cmd_we_n_i,
  input wire logic [2:0] bank_addr_i,
  input wire logic [emr_pkg::EMR_ADDR_W-1:0] addr_i,
  // Device state and strobe sources
  input wire logic self_refresh_i,
  input wire logic odt_i,
  input wire logic odt_state_ok_i,
  input wire logic org_x8_i,
  input wire logic read_drive_i,
  input wire logic dqs_i,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Decoded settings and strobe controls
  output var emr_pkg::emr_fields_s fields_o,
  output var emr_pkg::emr_strobe_oe_s strobe_oe_o,
  output logic rdqs_o,
  output logic odt_on_o,
  output logic dll_reset_o,
  output logic dll_locked_o,
  output logic [emr_pkg::EMR_LAT_W-1:0] read_latency_o,
  output logic [emr_pkg::EMR_LAT_W-1:0] write_latency_o,
  output logic rw_issue_o,
  output logic rw_issue_write_o
);
  // ----------------------------------------------------------------
  // Reset release and command decode
  // ----------------------------------------------------------------
  localparam logic [EMR_LOCK_CNT_W-1:0] LOCK_LAST = EMR_LOCK_CNT_W'(EMR_DLL_LOCK_CLOCKS - 1);
  typedef enum logic [1:0] {DLL_OFF, DLL_LOCKING, DLL_LOCKED} emr_dll_e;

  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [EMR_REG_W-1:0] ext1_reg;
  logic [EMR_REG_W-1:0] ext2_reg;
  logic [2:0] cl_reg;
  logic sr_reg;
  emr_dll_e dll_state_reg;
  logic [EMR_LOCK_CNT_W-1:0] lock_cnt_reg;
  logic [EMR_AL_DEPTH-1:0] rw_pipe_reg;
  logic [EMR_AL_DEPTH-1:0] wr_pipe_reg;
  wire logic cmd_sel = !cmd_cs_n_i;
  wire logic load_cmd = cmd_sel && !cmd_ras_n_i && !cmd_cas_n_i && !cmd_we_n_i;
  wire logic rw_cmd = cmd_sel && cmd_ras_n_i && !cmd_cas_n_i;
  wire logic load_ext1 = load_cmd && (bank_addr_i[1:0] == EMR_BA_EXT1[1:0]);
  wire logic load_ext2 = load_cmd && (bank_addr_i[1:0] == EMR_BA_EXT2[1:0]);

  // Two-stage reset release
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------------------------------
  // Mode register storage
  // ----------------------------------------------------------------
  // load only on command
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ext1_reg <= EMR_EXT1_RESET;
      ext2_reg <= EMR_EXT2_RESET;
    end else begin
      if (load_ext1) begin
        ext1_reg <= addr_i[EMR_REG_W-1:0];
      end
      if (load_ext2) begin
        ext2_reg <= addr_i[EMR_REG_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  // termination pair decode
  function automatic emr_rtt_e rtt_decode(input logic hi, input logic lo);
    rtt_decode = emr_rtt_e'({hi, lo});
  endfunction : rtt_decode

  wire logic [EMR_AL_W-1:0] al_raw = ext1_reg[EMR_AL_LSB +: EMR_AL_W];
  wire logic [EMR_AL_W-1:0] al_val = (al_raw > EMR_AL_MAX) ? EMR_AL_MAX : al_raw;
  wire logic dll_bit_on = !ext1_reg[EMR_DLL_DIS_POS];
  wire logic comp_en = !ext1_reg[EMR_COMP_DIS_POS];
  wire logic rdqs_en = ext1_reg[EMR_RDQS_EN_POS] && org_x8_i;
  wire logic out_en = !ext1_reg[EMR_OUT_DIS_POS];

  // Settings presented to the rest of the device
  // DLL enable from DLL state, not the control bit alone
  assign fields_o.dll_enable = (dll_state_reg != DLL_OFF);
  assign fields_o.drive_reduced = ext1_reg[EMR_DRIVE_POS];
  assign fields_o.rtt = rtt_decode(ext1_reg[EMR_TERM_HI_POS], ext1_reg[EMR_TERM_LO_POS]);
  assign fields_o.additive_latency = al_val;
  assign fields_o.ocd = ext1_reg[EMR_OCD_LSB +: EMR_OCD_W];
  assign fields_o.comp_strobe_en = comp_en;
  assign fields_o.redundant_strobe_en = rdqs_en;
  assign fields_o.output_en = out_en;
  assign fields_o.refresh_fast = ext2_reg[EMR_REFRESH_POS];

  // ----------------------------------------------------------------
  // Output enables and termination
  // ----------------------------------------------------------------
  // output disable
  assign strobe_oe_o.dq_oe = read_drive_i && out_en;
  assign strobe_oe_o.dqs_oe = read_drive_i && out_en;
  assign strobe_oe_o.dqs_comp_oe = read_drive_i && out_en && comp_en;
  assign strobe_oe_o.rdqs_oe = read_drive_i && out_en && rdqs_en;
  assign strobe_oe_o.rdqs_comp_oe = read_drive_i && out_en && rdqs_en && comp_en;
  assign rdqs_o = dqs_i && rdqs_en && read_drive_i;

  assign odt_on_o = (fields_o.rtt != EMR_RTT_OFF) && odt_i && odt_state_ok_i && !self_refresh_i;

  // ----------------------------------------------------------------
  // DLL control
  // ----------------------------------------------------------------
  // self refresh stops DLL, exit resets it
  wire logic sr_exit = sr_reg && !self_refresh_i;
  wire logic dll_enabling = (load_ext1 && !addr_i[EMR_DLL_DIS_POS] && !dll_bit_on) || (sr_exit && dll_bit_on);

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sr_reg <= 1'b0;
      dll_reset_o <= 1'b0;
    end else begin
      sr_reg <= self_refresh_i;
      dll_reset_o <= dll_enabling;
    end
  end

  // DLL state and 200-clock lock count
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dll_state_reg <= DLL_LOCKING;
      lock_cnt_reg <= '0;
    end else begin
      case (dll_state_reg)
        DLL_OFF: begin
          if (dll_enabling) begin
            dll_state_reg <= DLL_LOCKING;
            lock_cnt_reg <= '0;
          end
        end
        DLL_LOCKING, DLL_LOCKED: begin
          if (self_refresh_i || !dll_bit_on) begin
            dll_state_reg <= DLL_OFF;
          end else if (dll_state_reg == DLL_LOCKING && lock_cnt_reg == LOCK_LAST) begin
            dll_state_reg <= DLL_LOCKED;
          end else begin
            lock_cnt_reg <= lock_cnt_reg + 1'b1;
          end
        end
        default: dll_state_reg <= DLL_OFF;
      endcase
    end
  end
  assign dll_locked_o = (dll_state_reg == DLL_LOCKED);

  // ----------------------------------------------------------------
  // Latencies and posted command delay
  // ----------------------------------------------------------------
  // read and write latency
  assign read_latency_o = EMR_LAT_W'(al_val) + EMR_LAT_W'(cl_reg);
  assign write_latency_o = read_latency_o - 1'b1;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rw_pipe_reg <= '0;
      wr_pipe_reg <= '0;
    end else begin
      rw_pipe_reg <= {rw_pipe_reg[EMR_AL_DEPTH-2:0], rw_cmd};
      wr_pipe_reg <= {wr_pipe_reg[EMR_AL_DEPTH-2:0], rw_cmd && !cmd_we_n_i};
    end
  end
  wire logic [EMR_AL_W-1:0] tap = al_val - 1'b1;
  assign rw_issue_o = (al_val == '0) ? rw_cmd : rw_pipe_reg[tap];
  assign rw_issue_write_o = (al_val == '0) ? (rw_cmd && !cmd_we_n_i) : wr_pipe_reg[tap];

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_held_reg;
  logic w_held_reg;
  logic [3:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire logic aw_have = aw_held_reg || (s_axi_awvalid && s_axi_awready);
  wire logic w_have = w_held_reg || (s_axi_wvalid && s_axi_wready);
  wire logic [3:0] wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
  wire logic [31:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
  wire logic [3:0] wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
  wire logic wr_fire = aw_have && w_have && !s_axi_bvalid;
  wire logic wr_ctrl = wr_fire && (wr_addr == EMR_OFF_CTRL);
  wire logic wr_known = (wr_addr == EMR_OFF_EXT1) || (wr_addr == EMR_OFF_EXT2) || (wr_addr == EMR_OFF_STAT);
  wire logic [31:0] stat_word = {28'h000_0000, odt_on_o, self_refresh_i, dll_locked_o, fields_o.dll_enable};
  wire logic rd_known = (s_axi_araddr[1:0] == 2'h0);
  logic [31:0] rd_word;
  always_comb begin
    case (s_axi_araddr)
      EMR_OFF_EXT1: rd_word = {19'h0_0000, ext1_reg};
      EMR_OFF_EXT2: rd_word = {19'h0_0000, ext2_reg};
      EMR_OFF_CTRL: rd_word = {29'h000_0000, cl_reg};
      EMR_OFF_STAT: rd_word = stat_word;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Write channel capture, control register and response
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= EMR_RESP_OKAY;
      cl_reg <= EMR_CL_RESET;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_ctrl || wr_known) ? EMR_RESP_OKAY : EMR_RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held_reg <= 1'b1;
          aw_addr_reg <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held_reg <= 1'b1;
          w_data_reg <= s_axi_wdata;
          w_strb_reg <= s_axi_wstrb;
        end
      end
      if (wr_ctrl && wr_strb[0]) begin
        cl_reg <= wr_data[2:0];
      end
    end
  end

  // Read response
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= EMR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_known ? rd_word : 32'h0000_0000;
      s_axi_rresp <= rd_known ? EMR_RESP_OKAY : EMR_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_load1;
    load_ext1;
  endsequence
  sequence s_sr_exit_on;
    sr_reg && !self_refresh_i && dll_bit_on;
  endsequence

  property p_load_ext1;
    @(posedge core_clk_i) disable iff (!rst_n)
    s_load1 |=> ext1_reg == $past(addr_i[EMR_REG_W-1:0]);
  endproperty
  a_load_ext1: assert property (p_load_ext1) else $error("first register not loaded");

  property p_hold;
    @(posedge core_clk_i) disable iff (!rst_n)
    !load_ext1 && !load_ext2 |=> $stable(ext1_reg) && $stable(ext2_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("register changed without load");

  property p_load_ext2;
    @(posedge core_clk_i) disable iff (!rst_n)
    load_ext2 |=> fields_o.refresh_fast == $past(addr_i[EMR_REFRESH_POS]);
  endproperty
  a_load_ext2: assert property (p_load_ext2) else $error("refresh bit not loaded");

  property p_odt;
    @(posedge core_clk_i) disable iff (!rst_n)
    odt_on_o |-> odt_i && odt_state_ok_i && ext1_reg[EMR_TERM_HI_POS] | ext1_reg[EMR_TERM_LO_POS];
  endproperty
  a_odt: assert property (p_odt) else $error("termination on without cause");

  property p_latency;
    @(posedge core_clk_i) disable iff (!rst_n)
    write_latency_o + 1'b1 == EMR_LAT_W'(al_val) + EMR_LAT_W'(cl_reg);
  endproperty
  a_latency: assert property (p_latency) else $error("write latency mismatch");

  property p_out_dis;
    @(posedge core_clk_i) disable iff (!rst_n)
    ext1_reg[EMR_OUT_DIS_POS] |-> strobe_oe_o == '0;
  endproperty
  a_out_dis: assert property (p_out_dis) else $error("output driven while disabled");

  property p_sr_dll;
    @(posedge core_clk_i) disable iff (!rst_n)
    s_sr_exit_on |=> dll_reset_o ##0 fields_o.dll_enable;
  endproperty
  a_sr_dll: assert property (p_sr_dll) else $error("DLL not reset on exit");

  property p_al2;
    @(posedge core_clk_i) disable iff (!rst_n)
    rw_cmd && al_val == 3'h2 && $stable(al_val) |-> ##2 rw_issue_o;
  endproperty
  a_al2: assert property (p_al2) else $error("posted command not issued");

  property p_rdqs_comp;
    @(posedge core_clk_i) disable iff (!rst_n)
    strobe_oe_o.rdqs_comp_oe |-> ext1_reg[EMR_RDQS_EN_POS] && !ext1_reg[EMR_COMP_DIS_POS];
  endproperty
  a_rdqs_comp: assert property (p_rdqs_comp) else $error("redundant complement wrongly on");
endmodule : emr_top
`default_nettype wire

// >>> test/emr_ctrl_model.sv
// Memory controller model driving the command and address bus
`timescale 1ns/10ps
`default_nettype none
module emr_ctrl_model #(
  parameter int TMRD = 2
) (
  input wire logic clk_i,
  output logic [3:0] cmd_n_o,
  output logic [2:0] ba_o,
  output logic [15:0] addr_o
);
  // Bus starts deselected
  initial begin
    cmd_n_o = 4'hf;
    ba_o = 3'h0;
    addr_o = 16'h0;
  end
  // Deselect; address toggles so no stale value lingers
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk_i);
      cmd_n_o <= 4'hf;
      addr_o <= ~addr_o;
    end
  endtask : idle
  task automatic lm(input logic [1:0] sel, input logic [12:0] v);
    @(posedge clk_i);
    cmd_n_o <= 4'h0;
    ba_o <= {1'b0, sel};
    addr_o <= {3'h0, v[12:10], (sel == 2'b01) ? 3'h0 : v[9:7], v[6:0]};
    idle(TMRD + 1);
  endtask : lm
  // refresh then precharge-all while DLL is off
  task automatic refresh();
    @(posedge clk_i);
    cmd_n_o <= 4'h1;
    @(posedge clk_i);
    cmd_n_o <= 4'h2;
    addr_o <= 16'h0400;
    idle(1);
  endtask : refresh
  // Column read or write command
  task automatic rw(input logic wr);
    @(posedge clk_i);
    cmd_n_o <= {3'b010, ~wr};
    addr_o <= ~addr_o;
    idle(1);
  endtask : rw
endmodule : emr_ctrl_model
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the extended mode register block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import emr_pkg::*;
  logic core_clk_i = 1'b0, resetn_i = 1'b0, self_refresh_i = 1'b0, odt_i = 1'b0;
  logic odt_state_ok_i = 1'b1, org_x8_i = 1'b0, read_drive_i = 1'b0, dqs_i = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h34, r;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  emr_fields_s fields_o;
  emr_strobe_oe_s strobe_oe_o;
  logic rdqs_o, odt_on_o, dll_reset_o, dll_locked_o, rw_issue_o, rw_issue_write_o, prev_dis = 1'b0;
  logic [3:0] read_latency_o, write_latency_o;
  wire logic [3:0] cmd_n;
  wire logic [2:0] bank_addr_i;
  wire logic [15:0] addr_i;
  int n_errors = 0, n_checks = 0, cyc = 0, t_cmd = 0, n_rst = 0, k;
  logic [12:0] v;
  logic [33:0] axi_q[$];
  logic [32:0] iss_q[$];
  emr_top i_dut (
    .core_clk_i, .resetn_i, .cmd_cs_n_i(cmd_n[3]), .cmd_ras_n_i(cmd_n[2]), .cmd_cas_n_i(cmd_n[1]),
    .cmd_we_n_i(cmd_n[0]), .bank_addr_i, .addr_i, .self_refresh_i, .odt_i, .odt_state_ok_i, .org_x8_i,
    .read_drive_i, .dqs_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fields_o, .strobe_oe_o, .rdqs_o,
    .odt_on_o, .dll_reset_o, .dll_locked_o, .read_latency_o, .write_latency_o, .rw_issue_o, .rw_issue_write_o
  );
  emr_ctrl_model i_ctrl (.clk_i(core_clk_i), .cmd_n_o(cmd_n), .ba_o(bank_addr_i), .addr_o(addr_i));
  // Clock at 4 ns period
  initial begin
    forever #2 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Expected decoded fields from a first register value
  function automatic logic [13:0] ef(input logic [12:0] x, input logic e7, input logic x8);
    return {~x[0], x[1], x[6], x[2], x[5:3], 3'h0, ~x[10], x[11] & x8, ~x[12], e7};
  endfunction : ef
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  // One AXI4-Lite transfer; expected response noted first
  task automatic ax(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [33:0] e);
    axi_q.push_back(e);
    @(posedge core_clk_i);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    do begin
      @(posedge core_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_bvalid === 1'b1 || s_axi_rvalid === 1'b1));
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask : ax
  // Output watcher: takes the oldest note when a result appears
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    dqs_i <= ~dqs_i;
    if (dll_reset_o === 1'b1) n_rst++;
    if (cmd_n[3:1] === 3'b010) t_cmd = cyc;
    if (rw_issue_o === 1'b1) chk({cyc - t_cmd, rw_issue_write_o}, iss_q.pop_front());
    if (s_axi_bvalid === 1'b1 && s_axi_bready) chk({s_axi_bresp, 32'h0}, axi_q.pop_front());
    if (s_axi_rvalid === 1'b1 && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, axi_q.pop_front());
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge core_clk_i);
    n_errors++;
    complete_run();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    chk({fields_o, read_latency_o, write_latency_o, dll_locked_o}, {ef(13'h0, 0, 0), 9'h064});
    ax(0, EMR_OFF_CTRL, 0, {EMR_RESP_OKAY, 32'h3});
    ax(1, EMR_OFF_CTRL, 32'h5, {EMR_RESP_OKAY, 32'h0});
    ax(0, EMR_OFF_CTRL, 0, {EMR_RESP_OKAY, 32'h5});
    ax(1, 4'h2, 32'h5, {EMR_RESP_SLVERR, 32'h0});
    ax(0, 4'h2, 0, {EMR_RESP_SLVERR, 32'h0});
    repeat (200) @(posedge core_clk_i);
    chk(dll_locked_o, 1'b1);
    ax(0, EMR_OFF_STAT, 0, {EMR_RESP_OKAY, 32'h3});
    $display("test reset and bus done");
    for (int i = 0; i < 7; i++) begin
      r = rnd();
      v = (r[12:0] & 13'h1c03) | 13'(i << 3) | {6'h0, i[1], 3'h0, i[0], 2'h0};
      org_x8_i <= r[16];
      odt_state_ok_i <= r[17];
      read_drive_i <= r[18];
      odt_i <= 1'b0;
      k = n_rst;
      i_ctrl.lm(2'b01, v);
      chk(n_rst - k, prev_dis & ~v[0]);
      prev_dis = v[0];
      // refresh followed by precharge-all with DLL off
      if (v[0]) i_ctrl.refresh();
      repeat (8) @(posedge core_clk_i);
      odt_i <= r[19];
      @(posedge core_clk_i);
      chk({fields_o, read_latency_o, write_latency_o}, {ef(v, 0, r[16]), 4'(i + 5), 4'(i + 4)});
      chk(odt_on_o, (i % 4 != 0) & r[19] & r[17]);
      if (v[12]) chk(strobe_oe_o, 5'h0);
      else chk(strobe_oe_o, {{2{r[18]}}, r[18] & ~v[10],
                             {2{r[18] & v[11] & r[16]}} & {1'b1, ~v[10]}});
      chk(rdqs_o, dqs_i & v[11] & r[16] & r[18]);
      odt_i <= 1'b0;
      iss_q.push_back({32'(i), r[20]});
      i_ctrl.rw(r[20]);
      repeat (8) @(posedge core_clk_i);
    end
    $display("test field decode done");
    i_ctrl.lm(2'b10, 13'h0080);
    chk(fields_o.refresh_fast, 1'b1);
    ax(0, EMR_OFF_EXT2, 0, {EMR_RESP_OKAY, 32'h80});
    i_ctrl.lm(2'b00, 13'h0100);
    i_ctrl.lm(2'b11, 13'h1fff);
    ax(1, EMR_OFF_EXT1, 32'h0, {EMR_RESP_OKAY, 32'h0});
    ax(0, EMR_OFF_EXT1, 0, {EMR_RESP_OKAY, 19'h0, v});
    i_ctrl.lm(2'b01, 13'h0);
    k = n_rst;
    self_refresh_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    chk(fields_o.dll_enable, 1'b0);
    self_refresh_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    chk({fields_o.dll_enable, n_rst - k}, 33'h1_0000_0001);
    $display("test selection and self refresh done");
    complete_run();
  end
endmodule : tb
`default_nettype wire
